// [design/jtp_pkg.sv]
// Purpose: shared constants, state type and next-state function of the test port
// Assumes: four-bit instruction register, 32-bit identification register, 8-bit user register
// Notes: the state function is used both by the port logic and by its checks
package jtp_pkg;

  // ---------------------------------------------------------------
  // register widths and instruction codes
  // ---------------------------------------------------------------
  localparam int unsigned IR_W = 4;
  localparam int unsigned DR_W = 32;
  localparam int unsigned USER_W = 8;
  localparam logic [IR_W-1:0] IR_IDCODE = 4'h1;
  localparam logic [IR_W-1:0] IR_USER = 4'h2;
  localparam logic [IR_W-1:0] IR_BYPASS = 4'hF;
  localparam logic [IR_W-1:0] IR_CAPTURE = 4'h5;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [USER_W-1:0] USER_RST = 8'h00;
  localparam logic [DR_W-1:0] DR_RST = 32'h0000_0000;
  localparam int unsigned RESET_TMS_EDGES = 5;

  // ---------------------------------------------------------------
  // controller states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    S_RESET, S_IDLE,
    S_SEL_DR, S_CAP_DR, S_SH_DR, S_EX1_DR, S_PAU_DR, S_EX2_DR, S_UPD_DR,
    S_SEL_IR, S_CAP_IR, S_SH_IR, S_EX1_IR, S_PAU_IR, S_EX2_IR, S_UPD_IR
  } jtp_state_t;

  // next state for one test clock, steered by the mode select level
  function automatic jtp_state_t jtp_step(input jtp_state_t s, input logic tms);
    jtp_state_t n;
    n = S_RESET;
    unique case (s)
      S_RESET: n = tms ? S_RESET : S_IDLE;
      S_IDLE: n = tms ? S_SEL_DR : S_IDLE;
      S_SEL_DR: n = tms ? S_SEL_IR : S_CAP_DR;
      S_CAP_DR: n = tms ? S_EX1_DR : S_SH_DR;
      S_SH_DR: n = tms ? S_EX1_DR : S_SH_DR;
      S_EX1_DR: n = tms ? S_UPD_DR : S_PAU_DR;
      S_PAU_DR: n = tms ? S_EX2_DR : S_PAU_DR;
      S_EX2_DR: n = tms ? S_UPD_DR : S_SH_DR;
      S_UPD_DR: n = tms ? S_SEL_DR : S_IDLE;
      S_SEL_IR: n = tms ? S_RESET : S_CAP_IR;
      S_CAP_IR: n = tms ? S_EX1_IR : S_SH_IR;
      S_SH_IR: n = tms ? S_EX1_IR : S_SH_IR;
      S_EX1_IR: n = tms ? S_UPD_IR : S_PAU_IR;
      S_PAU_IR: n = tms ? S_EX2_IR : S_PAU_IR;
      S_EX2_IR: n = tms ? S_UPD_IR : S_SH_IR;
      S_UPD_IR: n = tms ? S_SEL_DR : S_IDLE;
    endcase
    return n;
  endfunction : jtp_step

endpackage : jtp_pkg

// [design/jtp_sync2.sv]
// Purpose: two-flop synchroniser for one level into the system clock
// Assumes: input is a slow level from another clock domain
// Notes: first stage feeds the second stage only
`timescale 1ns/1ps
module jtp_sync2 (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);

  logic meta_q;
  logic meta_d;
  logic sync_q;
  logic sync_d;

  // next values of the two stages
  always_comb begin
    meta_d = d;
    sync_d = meta_q;
  end

  // stage registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 1'b0;
      sync_q <= 1'b0;
    end else begin
      meta_q <= meta_d;
      sync_q <= sync_d;
    end
  end

  assign q = sync_q;

endmodule : jtp_sync2

// [design/jtp_tap.sv]
// Purpose: boundary-scan test access port with a user data register handed to system logic
// Assumes: tck comes from the external test host; sys_clk is the system clock
// Notes: user words cross to sys_clk by a toggle and a held data word
`timescale 1ns/1ps
module jtp_tap
  import jtp_pkg::*;
#(
  parameter logic [DR_W-1:0] ID_VALUE = 32'h0000_0001 // arbitrary identification value
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic tck,
  input wire logic trst_n,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic tdo_oe,
  output logic [USER_W-1:0] user_data,
  output logic user_valid
);

  // ---------------------------------------------------------------
  // test clock domain
  // ---------------------------------------------------------------
  jtp_state_t state_q;
  jtp_state_t state_d;
  logic tms_q;
  logic tms_d;
  logic [IR_W-1:0] ir_sr_q;
  logic [IR_W-1:0] ir_sr_d;
  logic [IR_W-1:0] ir_q;
  logic [IR_W-1:0] ir_d;
  logic [DR_W-1:0] dr_sr_q;
  logic [DR_W-1:0] dr_sr_d;
  logic byp_q;
  logic byp_d;
  logic [USER_W-1:0] user_q;
  logic [USER_W-1:0] user_d;
  logic tgl_q;
  logic tgl_d;
  logic tdo_q;
  logic tdo_d;
  logic oe_q;
  logic oe_d;
  logic sel_user;
  logic sel_id;

  assign sel_user = (ir_q == IR_USER);
  assign sel_id = (ir_q == IR_IDCODE);

  // rising edge: sample mode select and shift data in
  always_comb begin
    tms_d = tms;
    ir_sr_d = ir_sr_q;
    dr_sr_d = dr_sr_q;
    byp_d = byp_q;
    if (state_q == S_CAP_IR) begin
      ir_sr_d = IR_CAPTURE;
    end else if (state_q == S_SH_IR) begin
      ir_sr_d = {tdi, ir_sr_q[IR_W-1:1]};
    end else if (state_q == S_CAP_DR) begin
      byp_d = 1'b0;
      dr_sr_d = sel_user ? {{(DR_W-USER_W){1'b0}}, user_q} : ID_VALUE;
    end else if (state_q == S_SH_DR) begin
      byp_d = tdi;
      if (sel_user) begin
        dr_sr_d = {{(DR_W-USER_W){1'b0}}, tdi, dr_sr_q[USER_W-1:1]};
      end else begin
        dr_sr_d = {tdi, dr_sr_q[DR_W-1:1]};
      end
    end
  end

  // rising-edge registers, set at once by the test reset: tms_q high, ir_sr_q to IR_IDCODE, the rest cleared
  always_ff @(posedge tck or negedge trst_n) begin
    if (!trst_n) begin
      tms_q <= 1'b1;
      ir_sr_q <= IR_IDCODE;
      dr_sr_q <= DR_RST;
      byp_q <= 1'b0;
    end else begin
      tms_q <= tms_d;
      ir_sr_q <= ir_sr_d;
      dr_sr_q <= dr_sr_d;
      byp_q <= byp_d;
    end
  end

  // falling edge: step state, update instruction and user word, launch tdo
  always_comb begin
    state_d = jtp_step(state_q, tms_q);
    ir_d = ir_q;
    user_d = user_q;
    tgl_d = tgl_q;
    // instruction forced as the reset state is entered, so it holds from the first reset cycle
    if (state_d == S_RESET) begin
      ir_d = IR_IDCODE;
    end else if (state_q == S_UPD_IR) begin
      ir_d = ir_sr_q;
    end else if (state_q == S_UPD_DR && sel_user) begin
      user_d = dr_sr_q[USER_W-1:0];
      tgl_d = ~tgl_q;
    end
    oe_d = (state_d == S_SH_DR) || (state_d == S_SH_IR);
    if (state_d == S_SH_IR) begin
      tdo_d = ir_sr_q[0];
    end else if (state_d == S_SH_DR) begin
      tdo_d = (sel_user || sel_id) ? dr_sr_q[0] : byp_q;
    end else begin
      tdo_d = 1'b0;
    end
  end

  // falling-edge registers
  always_ff @(negedge tck or negedge trst_n) begin
    if (!trst_n) begin
      state_q <= S_RESET;
      ir_q <= IR_IDCODE;
      user_q <= USER_RST;
      tgl_q <= 1'b0;
      tdo_q <= 1'b0;
      oe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      ir_q <= ir_d;
      user_q <= user_d;
      tgl_q <= tgl_d;
      tdo_q <= tdo_d;
      oe_q <= oe_d;
    end
  end

  assign tdo = tdo_q;
  assign tdo_oe = oe_q;

  // ---------------------------------------------------------------
  // system clock domain
  // ---------------------------------------------------------------
  logic tgl_s;
  logic seen_q;
  logic seen_d;
  logic [USER_W-1:0] data_q;
  logic [USER_W-1:0] data_d;
  logic valid_q;
  logic valid_d;

  // toggle crosses as a level; the word is held for many tck periods
  jtp_sync2 u_sync (
    .clk(sys_clk),
    .rst_n(arst_n),
    .d(tgl_q),
    .q(tgl_s)
  );

  // take the held user word once per toggle
  always_comb begin
    seen_d = tgl_s;
    valid_d = tgl_s ^ seen_q;
    data_d = valid_d ? user_q : data_q;
  end

  // system registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      seen_q <= 1'b0;
      valid_q <= 1'b0;
      data_q <= USER_RST;
    end else begin
      seen_q <= seen_d;
      valid_q <= valid_d;
      data_q <= data_d;
    end
  end

  assign user_data = data_q;
  assign user_valid = valid_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  sequence five_tms_high;
    tms[*5];
  endsequence

  sequence shift_user;
    state_q == S_SH_DR && sel_user;
  endsequence

  shift_sample_a: assert property (@(posedge tck) disable iff (!trst_n)
    shift_user |=> dr_sr_q[USER_W-1] == $past(tdi))
    else $error("user shift did not take tdi");

  bypass_sample_a: assert property (@(posedge tck) disable iff (!trst_n)
    (state_q == S_SH_DR && ir_q == IR_BYPASS) |=> byp_q == $past(tdi))
    else $error("bypass did not take tdi");

  tdo_launch_a: assert property (@(posedge tck) disable iff (!trst_n)
    shift_user |-> tdo == dr_sr_q[0])
    else $error("tdo not launched from shift lsb");

  tdo_release_a: assert property (@(posedge tck) disable iff (!trst_n)
    tdo_oe == (state_q == S_SH_DR || state_q == S_SH_IR))
    else $error("tdo enable outside shift");

  tms_step_a: assert property (@(posedge tck) disable iff (!trst_n)
    ##1 state_q == jtp_step($past(state_q), $past(tms)))
    else $error("state step not steered by tms");

  fall_step_a: assert property (@(negedge tck) disable iff (!trst_n)
    (state_q == S_SH_DR && tms_q) |=> state_q == S_EX1_DR)
    else $error("no exit from shift on falling edge");

  trst_async_a: assert property (@(posedge tck)
    !trst_n |-> state_q == S_RESET && !tdo_oe)
    else $error("test reset not applied");

  reset_reach_a: assert property (@(posedge tck) disable iff (!trst_n)
    five_tms_high |=> state_q == S_RESET && ir_q == IR_IDCODE)
    else $error("five tms high did not reset");

endmodule : jtp_tap

// [testbench/jtp_host.sv]
// Purpose: behavioural test host driving the test port pins
// Assumes: tck rests low and only runs inside a step
// Notes: tms and tdi start high, as the pin pull-ups would leave them; each step leaves its own levels on them
`timescale 1ns/1ps
module jtp_host (
  output logic tck,
  output logic trst_n,
  output logic tms,
  output logic tdi,
  input wire logic tdo,
  input wire logic tdo_oe
);
  // ---------------------------------------------------------------
  // pin levels at rest
  // ---------------------------------------------------------------
  initial begin
    tck = 1'b0;
    trst_n = 1'b1;
    tms = 1'b1;
    tdi = 1'b1;
    // clean falling edge on the test reset, whatever order processes start in
    #2;
    trst_n = 1'b0;
  end

  // apply or release test reset, tck left still
  task automatic set_trst(input logic v);
    trst_n = v;
  endtask : set_trst

  // one tck period, 80 ns low then 80 ns high
  task automatic step(input logic m, input logic d, output logic so, output logic oe_r,
    output logic oe_f);
    #1;
    tms = m;
    tdi = d;
    #79;
    so = tdo;
    oe_r = tdo_oe;
    tck = 1'b1;
    #80;
    oe_f = tdo_oe;
    tck = 1'b0;
  endtask : step
endmodule : jtp_host

// [testbench/tb_jtag_tap_pin_interface.sv]
// Purpose: self-checking bench for the test access port
// Assumes: host model walks the controller from run-test/idle
// Notes: user words are caught by a monitor on the system clock
`timescale 1ns/1ps
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_jtag_tap_pin_interface import jtp_pkg::*;;
  localparam logic [DR_W-1:0] ID_T = 32'h0000_0ACF; // arbitrary identification value
  localparam int LIMIT = 20000;
  typedef struct {logic [IR_W-1:0] ir; int n; logic [31:0] exp;} jtp_row_t;
  logic sys_clk, arst_n, tck, trst_n, tms, tdi, tdo, tdo_oe, user_valid;
  logic [USER_W-1:0] user_data, last_word;
  logic [31:0] got;
  int fail_count, cmp_count, cyc, vcnt;
  jtp_row_t rows [4];

  jtp_tap #(.ID_VALUE(ID_T)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .tck(tck),
    .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(tdo_oe),
    .user_data(user_data), .user_valid(user_valid));
  jtp_host host (.tck(tck), .trst_n(trst_n), .tms(tms), .tdi(tdi), .tdo(tdo),
    .tdo_oe(tdo_oe));

  // ---------------------------------------------------------------
  // clock, user word monitor and timeout
  // ---------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) begin
    cyc++;
    if (user_valid === 1'b1) begin
      vcnt++;
      last_word = user_data;
    end
    if (cyc == LIMIT) begin
      fail_count++;
      conclude();
    end
  end

  // tms pattern, lsb first, tdi held high
  task automatic walk(input logic [15:0] pat, input int n);
    logic t, o, h;
    for (int k = 0; k < n; k++) begin
      host.step(pat[k], 1'b1, t, o, h);
    end
  endtask : walk

  // full scan from idle back to idle, lsb first
  task automatic scan(input logic is_ir, input logic [31:0] din, input int n,
    output logic [31:0] dout);
    logic t, o, h;
    dout = 32'h0;
    walk(is_ir ? 16'h0003 : 16'h0001, is_ir ? 3 : 2);
    host.step(1'b0, 1'b1, t, o, h);
    `CHK(h, 1'b0)
    for (int i = 0; i < n; i++) begin
      host.step(i == n - 1, din[i], t, o, h);
      dout[i] = t;
      `CHK(o, 1'b1)
    end
    host.step(1'b1, 1'b1, t, o, h);
    `CHK(o, 1'b0)
    host.step(1'b0, 1'b1, t, o, h);
  endtask : scan

  // counts, verdict and end of run
  task automatic conclude();
    $display("comparisons=%0d mismatches=%0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : conclude

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    arst_n = 1'b0;
    fail_count = 0;
    cmp_count = 0;
    cyc = 0;
    vcnt = 0;
    rows = '{'{IR_IDCODE, 32, ID_T}, '{IR_BYPASS, 2, 32'h2}, '{4'h7, 2, 32'h2},
      '{IR_USER, 8, 32'h0}};
    repeat (5) @(posedge sys_clk);
    arst_n <= 1'b1;
    @(posedge sys_clk);
    `CHK(user_data, USER_RST)
    `CHK(tdo_oe, 1'b0)
    `CHK(tdo, 1'b0)
    host.set_trst(1'b1);
    // leave test-logic-reset for run-test/idle before the first scan
    walk(16'h0000, 1);
    // instruction then data scan per row
    foreach (rows[k]) begin
      scan(1'b1, {28'h0, rows[k].ir}, IR_W, got);
      `CHK(got[IR_W-1:0], IR_CAPTURE)
      scan(1'b0, 32'hFFFF_FFFF, rows[k].n, got);
      `CHK(got, rows[k].exp)
    end
    // user words crossing, with readback of the previous word
    repeat (10) @(posedge sys_clk);
    `CHK(vcnt, 1)
    `CHK(last_word, 8'hFF)
    scan(1'b0, 32'hA5, USER_W, got);
    `CHK(got, 32'hFF)
    repeat (10) @(posedge sys_clk);
    `CHK(vcnt, 2)
    `CHK(last_word, 8'hA5)
    // five tms-high edges from shift-dr restore the identification code
    scan(1'b1, {28'h0, IR_BYPASS}, IR_W, got);
    walk(16'h00F9, 9);
    scan(1'b0, 32'h0, 32, got);
    `CHK(got, ID_T)
    // test reset in mid-shift with tck still
    scan(1'b1, {28'h0, IR_BYPASS}, IR_W, got);
    walk(16'h0001, 3);
    #20;
    `CHK(tdo_oe, 1'b1)
    host.set_trst(1'b0);
    #20;
    `CHK(tdo_oe, 1'b0)
    `CHK(tdo, 1'b0)
    // tck runs with tms high while reset is held
    walk(16'h0003, 2);
    `CHK(tdo_oe, 1'b0)
    #20;
    host.set_trst(1'b1);
    walk(16'h0000, 1);
    scan(1'b0, 32'h0, 32, got);
    `CHK(got, ID_T)
    `CHK(vcnt, 2)
    conclude();
  end
endmodule : tb_jtag_tap_pin_interface
